// ==== hw/epw_pkg.sv ====
// Constants for the enhanced PWM unit and its timebase timer.
// Assumes a single 250 MHz system clock and synchronous active-high reset.
// Summary of operation
// R1: Timer counts internal clock or external edges
// R2: Count readable and writable as two bytes
// R3: Clock source: device clock, secondary oscillator, external
// R4: Special event trigger resets the timer
// R5: Timer control selects clock offered to PWM; the PWM phase counter here steps on every sys_clk cycle
// R6: Configurer avoids raw clock for capture/compare
// R7: One 16-bit capture/compare/duty register per unit
// R8: Two/four channels, steering, polarity, dead-band, shutdown
// R9: Up to four pins, 10-bit duty resolution
// R10: Arrangement field selects single, half, full fwd/rev
// R11: Unit mode field sets output pin polarity
// R12: Output held until next period starts; full-bridge pin A (fwd) or C (rev) goes active at once
// R13: Unused pins left free for other functions
// R14: Software sets pin direction for PWM pins
// R15: Overflow flag set on rollover to zero
`default_nettype none

package epw_pkg;
    // Clock source selection in timebase control
    localparam logic [1:0] CLK_SRC_DEVICE = 2'h0;
    localparam logic [1:0] CLK_SRC_RAW_OSC = 2'h1;
    localparam logic [1:0] CLK_SRC_SEC_OSC = 2'h2;
    localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h3;
    // Output arrangement field codes
    localparam logic [1:0] ARR_SINGLE = 2'h0;
    localparam logic [1:0] ARR_FULL_FWD = 2'h1;
    localparam logic [1:0] ARR_HALF = 2'h2;
    localparam logic [1:0] ARR_FULL_REV = 2'h3;
    // Unit mode field: bit 1 inverts A/C, bit 0 inverts B/D
    localparam int MODE_POL_AC_BIT = 1;
    localparam int MODE_POL_BD_BIT = 0;
    localparam logic [3:0] MODE_PWM_BASE = 4'hc;
    localparam logic [3:0] MODE_CAPTURE_BASE = 4'h4;
    localparam int DUTY_BITS = 10;
    localparam int COUNT_BITS = 16;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
    localparam logic [7:0] DEADBAND_RESET = 8'h00;
endpackage

`default_nettype wire

// ==== hw/epw_timebase.sv ====
// Sixteen-bit timebase timer with byte access and overflow event.
// Assumes every input is synchronous to sys_clk.
`default_nettype none

module epw_timebase
    import epw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic timer_on,
    input wire logic [1:0] clk_src_sel,
    input wire logic sec_osc_tick,
    input wire logic ext_clk_in,
    input wire logic special_event_trigger,
    input wire logic count_high_byte_wr,
    input wire logic count_low_byte_wr,
    input wire logic [7:0] wr_data,
    output logic [7:0] count_high_byte,
    output logic [7:0] count_low_byte,
    output logic [15:0] count_value,
    output logic overflow_pulse
);
    logic [15:0] count_reg, count_next;
    logic ext_prev_reg, ext_prev_next;
    logic ovf_reg, ovf_next;
    logic tick;

    ////////////////////////////////////////////////////////////////////
    // Tick source: device clock, raw oscillator, secondary oscillator or ext rising edge
    always_comb
    begin
        case (clk_src_sel)
            CLK_SRC_DEVICE: tick = 1'b1; // see R1 see R3
            CLK_SRC_RAW_OSC: tick = 1'b1;
            CLK_SRC_SEC_OSC: tick = sec_osc_tick; // see R3
            CLK_SRC_EXTERNAL: tick = ext_clk_in & ~ext_prev_reg; // see R1
            default: tick = 1'b0;
        endcase
    end

    // Trigger wins over byte writes so a reset is never lost
    always_comb
    begin
        count_next = count_reg;
        ovf_next = 1'b0;
        ext_prev_next = ext_clk_in;
        if (special_event_trigger)
            count_next = COUNT_RESET; // see R4
        else if (count_high_byte_wr || count_low_byte_wr)
        begin
            if (count_high_byte_wr)
                count_next[15:8] = wr_data; // see R2
            if (count_low_byte_wr)
                count_next[7:0] = wr_data; // see R2
        end
        else if (timer_on && tick)
        begin
            count_next = count_reg + 16'h0001;
            ovf_next = (count_reg == COUNT_ALL_ONES); // see R15
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            count_reg <= COUNT_RESET;
            ext_prev_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            ext_prev_reg <= ext_prev_next;
            ovf_reg <= ovf_next;
        end
    end

    assign count_high_byte = count_reg[15:8];
    assign count_low_byte = count_reg[7:0];
    assign count_value = count_reg;
    assign overflow_pulse = ovf_reg;
endmodule

`default_nettype wire

// ==== hw/epw_top.sv ====
// Enhanced PWM unit with its timebase timer, control bits as ports.
// Assumes synchronous inputs; pin ownership is shown on pin_direction_control.
`default_nettype none

module epw_top
    import epw_pkg::*;
#(
    parameter int DUTY_W = DUTY_BITS,
    parameter int DEAD_W = 8
)
(
    input wire logic sys_clk,
    input wire logic rst,
    // Timebase control
    input wire logic timer_on,
    input wire logic [1:0] clk_src_sel,
    input wire logic sec_osc_tick,
    input wire logic ext_clk_in,
    input wire logic special_event_trigger,
    input wire logic count_high_byte_wr,
    input wire logic count_low_byte_wr,
    input wire logic [7:0] wr_data,
    output logic [7:0] count_high_byte,
    output logic [7:0] count_low_byte,
    input wire logic overflow_flag_clr,
    output logic overflow_flag,
    // Unit control
    input wire logic [3:0] unit_mode_field,
    input wire logic [1:0] output_arrangement_field,
    input wire logic [7:0] period_value,
    input wire logic [15:0] unit_value_wr_data,
    input wire logic unit_value_wr,
    input wire logic capture_in,
    output logic [15:0] unit_value,
    input wire logic [DEAD_W-1:0] deadband_delay,
    input wire logic [3:0] steer_enable,
    input wire logic shutdown_in,
    input wire logic auto_restart,
    input wire logic shutdown_clr,
    output logic shutdown_status,
    output logic [3:0] pin_direction_control,
    output logic pwm_out_a,
    output logic pwm_out_b,
    output logic pwm_out_c,
    output logic pwm_out_d,
    output logic pwm_active
);
    logic [15:0] count_value;
    logic ovf_pulse;
    logic pwm_mode;

    ////////////////////////////////////////////////////////////////////
    // Timebase; raw oscillator clock kept selectable, caller avoids it
    epw_timebase u_timebase (
        .sys_clk(sys_clk),
        .rst(rst),
        .timer_on(timer_on),
        .clk_src_sel(clk_src_sel), // see R5
        .sec_osc_tick(sec_osc_tick),
        .ext_clk_in(ext_clk_in),
        .special_event_trigger(special_event_trigger),
        .count_high_byte_wr(count_high_byte_wr),
        .count_low_byte_wr(count_low_byte_wr),
        .wr_data(wr_data),
        .count_high_byte(count_high_byte),
        .count_low_byte(count_low_byte),
        .count_value(count_value),
        .overflow_pulse(ovf_pulse)
    );

    assign pwm_mode = (unit_mode_field[3:2] == MODE_PWM_BASE[3:2]);

    ////////////////////////////////////////////////////////////////////
    // Sticky overflow flag: event beats a same-cycle clear
    logic ovf_flag_reg, ovf_flag_next;
    always_comb
    begin
        ovf_flag_next = ovf_flag_reg;
        if (overflow_flag_clr)
            ovf_flag_next = 1'b0;
        if (ovf_pulse)
            ovf_flag_next = 1'b1; // see R15
    end

    ////////////////////////////////////////////////////////////////////
    // Shared 16-bit register: capture, compare or duty
    logic [15:0] value_reg, value_next;
    logic cap_prev_reg;
    always_comb
    begin
        value_next = value_reg;
        if (unit_value_wr)
            value_next = unit_value_wr_data; // see R7
        else if (unit_mode_field[3:2] == MODE_CAPTURE_BASE[3:2] &&
                 capture_in && !cap_prev_reg)
            value_next = count_value; // see R7
    end

    ////////////////////////////////////////////////////////////////////
    // PWM period engine on an 8-bit period with 10-bit duty
    typedef enum logic [2:0] {
        EPW_IDLE = 3'b001,
        EPW_WAIT = 3'b010,
        EPW_RUN = 3'b100
    } epw_state_e;
    epw_state_e state_reg, state_next;
    logic [DUTY_W-1:0] phase_reg, phase_next;
    logic [DUTY_W-1:0] duty_reg, duty_next;
    logic [DUTY_W-1:0] period_end;
    logic period_wrap;
    logic raw_pwm;

    // Phase counts in quarter steps, giving two extra duty bits
    assign period_end = {period_value, 2'h3};
    assign period_wrap = (phase_reg == period_end);

    always_comb
    begin
        state_next = state_reg;
        phase_next = period_wrap ? '0 : phase_reg + 1'b1;
        duty_next = duty_reg;
        if (period_wrap)
            duty_next = value_reg[DUTY_W-1:0]; // see R9
        case (state_reg)
            EPW_IDLE:
            begin
                phase_next = '0;
                if (pwm_mode)
                    state_next = EPW_WAIT;
            end
            // Only the full-bridge steady pin (A fwd, C rev) goes active until a fresh period begins
            EPW_WAIT:
            begin
                if (!pwm_mode)
                    state_next = EPW_IDLE;
                else if (period_wrap)
                    state_next = EPW_RUN; // see R12
            end
            EPW_RUN:
            begin
                if (!pwm_mode)
                    state_next = EPW_IDLE;
            end
            default: state_next = EPW_IDLE;
        endcase
    end

    assign raw_pwm = (state_reg == EPW_RUN) && (phase_reg < duty_reg);

    ////////////////////////////////////////////////////////////////////
    // Dead-band: delay each rising edge of the complementary pair
    logic [DEAD_W-1:0] dead_cnt_reg, dead_cnt_next;
    logic raw_prev_reg;
    logic dead_ok;
    // Edge cycle itself is blanked, else the dead time falls a cycle short
    always_comb
    begin
        dead_cnt_next = dead_cnt_reg;
        dead_ok = (dead_cnt_reg == '0);
        if (raw_pwm != raw_prev_reg)
        begin
            dead_ok = (deadband_delay == '0); // see R8
            if (deadband_delay != '0)
                dead_cnt_next = deadband_delay - 1'b1;
            else
                dead_cnt_next = '0;
        end
        else if (dead_cnt_reg != '0)
            dead_cnt_next = dead_cnt_reg - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Auto-shutdown latch; auto restart frees it at period start
    logic shut_reg, shut_next;
    always_comb
    begin
        shut_next = shut_reg;
        if (shutdown_clr || (auto_restart && !shutdown_in && period_wrap))
            shut_next = 1'b0;
        if (shutdown_in)
            shut_next = 1'b1; // see R8
    end

    ////////////////////////////////////////////////////////////////////
    // Arrangement decode: active-high levels and used-pin mask
    logic [3:0] lvl;
    logic [3:0] used;
    logic hi_a, hi_b;
    assign hi_a = raw_pwm && dead_ok;
    assign hi_b = !raw_pwm && dead_ok && (state_reg == EPW_RUN);
    always_comb
    begin
        case (output_arrangement_field) // see R10
            ARR_SINGLE:
            begin
                lvl = {4{raw_pwm}};
                used = steer_enable; // see R8
            end
            ARR_HALF:
            begin
                lvl = {2'h0, hi_b, hi_a};
                used = 4'h3; // see R8
            end
            ARR_FULL_FWD:
            begin
                lvl = {raw_pwm, 2'h0, 1'b1};
                used = 4'hf;
            end
            ARR_FULL_REV:
            begin
                lvl = {2'h0, raw_pwm, 1'b0};
                lvl[2] = 1'b1;
                used = 4'hf;
            end
            default:
            begin
                lvl = 4'h0;
                used = 4'h0;
            end
        endcase
    end

    // Polarity, shutdown forcing and pin ownership per pin
    logic [3:0] pin_reg, pin_next;
    logic [3:0] own_reg, own_next;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pin
            logic inv;
            assign inv = (gi % 2 == 0) ? unit_mode_field[MODE_POL_AC_BIT]
                                       : unit_mode_field[MODE_POL_BD_BIT];
            // Shutdown parks pins at their inactive level
            assign pin_next[gi] = (shut_reg ? 1'b0 : lvl[gi]) ^ inv; // see R11
            assign own_next[gi] = pwm_mode && used[gi]; // see R13
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ovf_flag_reg <= 1'b0;
            value_reg <= COUNT_RESET;
            cap_prev_reg <= 1'b0;
            state_reg <= EPW_IDLE;
            phase_reg <= '0;
            duty_reg <= '0;
            dead_cnt_reg <= '0;
            raw_prev_reg <= 1'b0;
            shut_reg <= 1'b0;
            pin_reg <= 4'h0;
            own_reg <= 4'h0;
        end
        else
        begin
            ovf_flag_reg <= ovf_flag_next;
            value_reg <= value_next;
            cap_prev_reg <= capture_in;
            state_reg <= state_next;
            phase_reg <= phase_next;
            duty_reg <= duty_next;
            dead_cnt_reg <= dead_cnt_next;
            raw_prev_reg <= raw_pwm;
            shut_reg <= shut_next;
            pin_reg <= pin_next;
            own_reg <= own_next;
        end
    end

    assign overflow_flag = ovf_flag_reg;
    assign unit_value = value_reg;
    assign shutdown_status = shut_reg;
    // Software must still set pin direction; this shows ownership
    assign pin_direction_control = own_reg; // see R14
    assign pwm_out_a = pin_reg[0];
    assign pwm_out_b = pin_reg[1];
    assign pwm_out_c = pin_reg[2];
    assign pwm_out_d = pin_reg[3];
    assign pwm_active = (state_reg == EPW_RUN);
endmodule

`default_nettype wire

// ==== verif/epw_pin_load.sv ====
// Load on the four PWM pins, in place of a bridge driver.
// Assumes pins and ownership come straight from the unit.
`default_nettype none

module epw_pin_load
(
    input wire logic [3:0] pin_level,
    input wire logic [3:0] pin_owned,
    output logic [3:0] load_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pins not owned by the PWM read low through a pull-down
    assign load_level = pin_level & pin_owned;
endmodule

`default_nettype wire

// ==== verif/epw_top_properties.sv ====
// Checker on the top module ports: timer and PWM relations.
// Assumes one clock domain and the bind at the foot.
`default_nettype none

module epw_top_checker
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic timer_on,
    input wire logic [1:0] clk_src_sel,
    input wire logic special_event_trigger,
    input wire logic count_high_byte_wr,
    input wire logic count_low_byte_wr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] count_high_byte,
    input wire logic [7:0] count_low_byte,
    input wire logic overflow_flag_clr,
    input wire logic overflow_flag,
    input wire logic [3:0] unit_mode_field,
    input wire logic [15:0] unit_value_wr_data,
    input wire logic unit_value_wr,
    input wire logic [15:0] unit_value,
    input wire logic [3:0] pin_direction_control,
    input wire logic pwm_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [15:0] cnt;
    logic quiet;
    // No write or trigger, so a tick is the only change
    assign cnt = {count_high_byte, count_low_byte};
    assign quiet = !count_high_byte_wr && !count_low_byte_wr
        && !special_event_trigger;
    ////////////////////////////////////////////////////////////////////
    a_trigger_clears: assert property (
        special_event_trigger |=> cnt == 16'h0000)
        else $error("count not cleared");
    a_low_write: assert property (
        count_low_byte_wr && !special_event_trigger
        |=> count_low_byte == $past(wr_data))
        else $error("low byte write lost");
    a_count_holds: assert property (
        !timer_on && quiet |=> $stable(cnt))
        else $error("count moved while off");
    a_device_tick: assert property (
        timer_on && !clk_src_sel[1] && quiet
        |=> cnt == $past(cnt) + 16'h0001)
        else $error("device clock tick missed");
    a_overflow_set: assert property (
        timer_on && !clk_src_sel[1] && quiet && cnt == 16'hffff
        |-> ##2 overflow_flag)
        else $error("overflow flag not set");
    a_flag_sticky: assert property (
        overflow_flag && !overflow_flag_clr |=> overflow_flag)
        else $error("overflow flag dropped");
    a_pin_owner: assert property (
        pin_direction_control != 4'h0
        |-> $past(unit_mode_field) >= 4'hc)
        else $error("pin owned outside PWM");
    a_enable_holdoff: assert property (
        $rose(unit_mode_field >= 4'hc) |-> !pwm_active [*4])
        else $error("PWM ran before period start");
    a_value_write: assert property (
        unit_value_wr |=> unit_value == $past(unit_value_wr_data))
        else $error("shared register write lost");
endmodule

bind epw_top epw_top_checker u_chk (.sys_clk, .rst, .timer_on,
    .clk_src_sel, .special_event_trigger, .count_high_byte_wr,
    .count_low_byte_wr, .wr_data, .count_high_byte, .count_low_byte,
    .overflow_flag_clr, .overflow_flag, .unit_mode_field,
    .unit_value_wr_data, .unit_value_wr, .unit_value,
    .pin_direction_control, .pwm_active);

`default_nettype wire

// ==== verif/tb_top.sv ====
// Bench for the PWM unit and timebase: pulse tasks and pin tables.
// Assumes package, design, load model and checker compile first.
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))

module tb_top
    import epw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst, timer_on, ext_clk_in, capture_in;
    logic shutdown_in, auto_restart, overflow_flag, shutdown_status;
    logic pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d, pwm_active;
    logic [1:0] clk_src_sel, output_arrangement_field;
    logic [3:0] unit_mode_field, steer_enable;
    logic [3:0] pin_direction_control, load_level;
    logic [7:0] wr_data, period_value, deadband_delay;
    logic [7:0] count_high_byte, count_low_byte;
    logic [15:0] unit_value_wr_data, unit_value;
    logic [6:0] pls;
    wire logic special_event_trigger, overflow_flag_clr, sec_osc_tick;
    wire logic shutdown_clr, unit_value_wr, count_low_byte_wr;
    wire logic count_high_byte_wr;
    int miscompares = 0;
    int cmp_count = 0;
    int na, nb, nboth, n_exp;
    // One vector for all pulse inputs, so one task raises any
    assign {count_high_byte_wr, count_low_byte_wr, unit_value_wr,
        shutdown_clr, sec_osc_tick, overflow_flag_clr,
        special_event_trigger} = pls;
    ////////////////////////////////////////////////////////////////////
    epw_top dut (.sys_clk, .rst, .timer_on, .clk_src_sel,
        .sec_osc_tick, .ext_clk_in, .special_event_trigger,
        .count_high_byte_wr, .count_low_byte_wr, .wr_data,
        .count_high_byte, .count_low_byte, .overflow_flag_clr,
        .overflow_flag, .unit_mode_field, .output_arrangement_field,
        .period_value, .unit_value_wr_data, .unit_value_wr,
        .capture_in, .unit_value, .deadband_delay, .steer_enable,
        .shutdown_in, .auto_restart, .shutdown_clr, .shutdown_status,
        .pin_direction_control, .pwm_out_a, .pwm_out_b, .pwm_out_c,
        .pwm_out_d, .pwm_active);
    epw_pin_load u_load (.pin_level({pwm_out_d, pwm_out_c, pwm_out_b,
        pwm_out_a}), .pin_owned(pin_direction_control), .load_level);
    ////////////////////////////////////////////////////////////////////
    // Clock, 4 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Watchdog, about five times the expected run
    initial
    begin
        #16000;
        miscompares++;
        results();
    end
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // One-cycle pulse on line k with write data d
    task automatic pulse(int k, logic [7:0] d);
        @(posedge sys_clk);
        wr_data <= d;
        pls[k] <= 1'b1;
        @(posedge sys_clk);
        pls <= '0;
        #1;
    endtask
    // Settled pin levels at full duty; a is bit 0, d is bit 3
    function automatic logic [3:0] exp_pins(int m);
        logic [3:0] act;
        case (2'(m >> 2))
            ARR_SINGLE: act = 4'hf;
            ARR_FULL_FWD: act = 4'h9;
            ARR_HALF: act = 4'h1;
            default: act = 4'h6;
        endcase
        act = act ^ {m[0], m[1], m[0], m[1]};
        return (2'(m >> 2) == ARR_HALF) ? (act & 4'h3) : act;
    endfunction
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {timer_on, ext_clk_in, capture_in, shutdown_in, auto_restart,
            clk_src_sel, output_arrangement_field, unit_mode_field,
            wr_data, deadband_delay, pls} = '0;
        rst = 1'b1;
        period_value = 8'h03;
        steer_enable = 4'hf;
        unit_value_wr_data = 16'h03ff;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        tick(1);
        pulse(6, 8'hab);
        pulse(5, 8'hcd);
        `CHK({count_high_byte, count_low_byte}, 16'habcd);
        // Three secondary oscillator ticks
        @(posedge sys_clk);
        timer_on <= 1'b1;
        clk_src_sel <= CLK_SRC_SEC_OSC;
        repeat (3) pulse(2, 8'h00);
        tick(2);
        `CHK(count_low_byte, 8'hd0);
        // Two rising edges on the external input
        @(posedge sys_clk);
        clk_src_sel <= CLK_SRC_EXTERNAL;
        repeat (4)
        begin
            @(posedge sys_clk);
            ext_clk_in <= !ext_clk_in;
        end
        tick(3);
        @(posedge sys_clk);
        timer_on <= 1'b0;
        tick(1);
        `CHK(count_low_byte, 8'hd2);
        pulse(0, 8'h00);
        `CHK({count_high_byte, count_low_byte}, 16'h0000);
        // Roll over from fffd on the device clock
        pulse(6, 8'hff);
        pulse(5, 8'hfd);
        // Raw clock is allowed while nothing captures
        @(posedge sys_clk);
        timer_on <= 1'b1;
        clk_src_sel <= CLK_SRC_RAW_OSC;
        @(posedge sys_clk);
        clk_src_sel <= CLK_SRC_DEVICE;
        tick(6);
        `CHK(overflow_flag, 1'b1);
        pulse(1, 8'h00);
        `CHK(overflow_flag, 1'b0);
        // Capture with the timer parked on the secondary oscillator
        @(posedge sys_clk);
        clk_src_sel <= CLK_SRC_SEC_OSC;
        unit_mode_field <= MODE_CAPTURE_BASE;
        pulse(6, 8'h12);
        pulse(5, 8'h34);
        @(posedge sys_clk);
        capture_in <= 1'b1;
        tick(2);
        `CHK(unit_value, 16'h1234);
        pulse(4, 8'h00);
        `CHK(unit_value, 16'h03ff);
        // Enable waits for a period start
        @(posedge sys_clk);
        unit_mode_field <= MODE_PWM_BASE;
        tick(2);
        `CHK(pwm_active, 1'b0);
        tick(40);
        `CHK(pwm_active, 1'b1);
        // Every arrangement with every polarity
        for (int m = 0; m < 16; m++)
        begin
            @(posedge sys_clk);
            output_arrangement_field <= 2'(m >> 2);
            unit_mode_field <= MODE_PWM_BASE | 4'(m & 3);
            tick(40);
            `CHK(load_level, exp_pins(m));
            n_exp = ((m >> 2) == 2) ? 2 : 4;
            `CHK($countones(pin_direction_control), n_exp);
        end
        // Shutdown forces inactive levels, clear releases
        @(posedge sys_clk);
        shutdown_in <= 1'b1;
        tick(4);
        `CHK(shutdown_status, 1'b1);
        `CHK(load_level, 4'hf);
        @(posedge sys_clk);
        shutdown_in <= 1'b0;
        pulse(3, 8'h00);
        `CHK(shutdown_status, 1'b0);
        // Steering picks the pins used in single mode
        @(posedge sys_clk);
        output_arrangement_field <= ARR_SINGLE;
        steer_enable <= 4'h5;
        tick(3);
        `CHK(pin_direction_control, 4'h5);
        // Auto restart frees the latch at a period start
        @(posedge sys_clk);
        auto_restart <= 1'b1;
        shutdown_in <= 1'b1;
        tick(2);
        `CHK(shutdown_status, 1'b1);
        @(posedge sys_clk);
        shutdown_in <= 1'b0;
        tick(20);
        `CHK(shutdown_status, 1'b0);
        // Half bridge at half duty: two dead cycles after each edge
        @(posedge sys_clk);
        output_arrangement_field <= ARR_HALF;
        unit_mode_field <= MODE_PWM_BASE;
        deadband_delay <= 8'h02;
        unit_value_wr_data <= 16'h0008;
        pulse(4, 8'h00);
        tick(40);
        {na, nb, nboth} = '0;
        repeat (16)
        begin
            tick(1);
            na += load_level[0];
            nb += load_level[1];
            nboth += load_level[0] & load_level[1];
        end
        `CHK(na, 6);
        `CHK(nb, 6);
        `CHK(nboth, 0);
        results();
    end
endmodule

`default_nettype wire
